// >>> hdl/cbc_params.svh
// Constants for the processor bus control pins, shared by both ends.
// Assumes one 10 MHz system clock; memory and fast clocks are enables.
// How it works
// - Low interrupt input taken only when enabled
// - Access request changes only in clock-low phase
// - Request low when next cycle is external
// - Reset aborts work, disables cache, translation, buffer
// - Fetching restarts from address zero after reset
// - Reset held max of two fast, five bus clocks
// - Idle cycles with rising addresses; wait high
// - Direction high write, low read, changes high phase
// - Test-port reset pulsed low for normal operation
// - Wait low stretches access; changes in low phase
// - Memory cycle flag is inverse of request
// - Strap input tied permanently high
// - All seventeen factory test inputs tied low
// - Test port transfers timed by test clock
// - Every access timed by memory bus clock
// - Latch enable low holds address and direction
`ifndef CBC_PARAMS_SVH
`define CBC_PARAMS_SVH
`define CBC_MCLK_DIV      8'h04
`define CBC_FAST_CORE_CLOCK_DIV      8'h01
`define CBC_RST_FAST_CORE_CLOCK_MIN  8'h02
`define CBC_RST_MCLK_MIN  8'h05
`define CBC_RESET_ADDR    32'h0000_0000
`define CBC_TEST_IN_W     17
`define CBC_TEST_OUT_W    3
`endif

// >>> hdl/cbc_pkg.sv
// Types shared by both ends of the processor bus control link.
// Assumes the constants header is included by each design file.
package cbc_pkg;
   typedef enum logic [1:0] {
      CBC_RESET,
      CBC_IDLE,
      CBC_ACCESS
   } cbc_dev_state_e;
   typedef logic [31:0] cbc_addr_t;
endpackage : cbc_pkg

// >>> hdl/cbc_if.sv
// Pins between the processor end and the memory controller end.
// Assumes both ends share i_clk; bus clock phase is a shared level.
`timescale 1ns/1ns
`default_nettype none
interface cbc_if;
   logic        mclk_high;
   logic        core_reset_n;
   logic        test_reset_n;
   logic        normal_int_req_n;
   logic        stall_request_n;
   logic        addr_latch_en;
   logic        strap_high_input;
   logic [16:0] factory_test_inputs;
   logic [2:0]  factory_test_outputs;
   logic        ext_access_req_n;
   logic        memory_cycle_flag;
   logic        write_not_read;
   logic [31:0] addr;
   modport dev (input mclk_high, core_reset_n, test_reset_n,
      normal_int_req_n, stall_request_n, addr_latch_en,
      strap_high_input, factory_test_inputs,
      output factory_test_outputs, ext_access_req_n,
      memory_cycle_flag, write_not_read, addr);
   modport mem (output mclk_high, core_reset_n, test_reset_n,
      normal_int_req_n, stall_request_n, addr_latch_en,
      strap_high_input, factory_test_inputs,
      input factory_test_outputs, ext_access_req_n,
      memory_cycle_flag, write_not_read, addr);
endinterface : cbc_if
`default_nettype wire

// >>> hdl/cbc_device.sv
// Processor end: drives request, direction, address, test outputs.
// Assumes the memory end supplies bus clock phase and control pins.
`timescale 1ns/1ns
`default_nettype none
`include "cbc_params.svh"
module cbc_device
   import cbc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   cbc_if.dev               bus,
   input  wire logic        i_int_enable,
   input  wire logic        i_want_access,
   input  wire logic        i_want_write,
   input  wire logic [31:0] i_access_addr,
   output logic             o_int_taken,
   output logic             o_access_done,
   output logic             o_units_enabled,
   output logic [31:0]      o_fetch_addr
);
   // Timing budget: each bus clock phase lasts CBC_MCLK_DIV clocks.
   // A pin seen through two flops and then the edge detector costs
   // three clocks, so the request and the direction move on the last
   // clock of the phase that they belong to at the default divider.
   // A divider below four would push them into the next phase; a
   // slower one only adds margin.

   // Sequencer state and the registers behind each pin
   cbc_dev_state_e state, next_state;
   logic [1:0]  irq_sync, rst_sync, stall_sync, ph_sync, tst_sync;
   logic        tst_ok, next_tst_ok;
   logic        flag, next_flag;
   logic        ph_prev, next_ph_prev;
   logic        req_n, next_req_n;
   logic        wr, next_wr;
   cbc_addr_t   addr, next_addr;
   cbc_addr_t   lat_addr, next_lat_addr;
   logic        lat_wr, next_lat_wr;
   logic        int_taken, next_int_taken;
   logic        done, next_done;
   logic        units, next_units;
   cbc_addr_t   fetch, next_fetch;
   logic        fall, rise;

   // Two-stage synchronisers on pins from outside. Only the second
   // flop of each pair is read, so a metastable first stage never
   // reaches the sequencer; the price is two clocks of lag
   // on each of these five pins.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_sync   <= 2'h3;
         rst_sync   <= 2'h0;
         stall_sync <= 2'h3;
         ph_sync    <= 2'h0;
         tst_sync   <= 2'h3;   // Idle high, so reset makes no false pulse
      end else begin
         irq_sync   <= {irq_sync[0], bus.normal_int_req_n};
         rst_sync   <= {rst_sync[0], bus.core_reset_n};
         stall_sync <= {stall_sync[0], bus.stall_request_n};
         ph_sync    <= {ph_sync[0], bus.mclk_high};
         tst_sync   <= {tst_sync[0], bus.test_reset_n};
      end
   end

   // Bus clock edges from the synchronised phase. ph_prev and the
   // synchroniser reset to the same low level, so no false edge
   // follows reset.
   assign fall = ph_prev & ~ph_sync[1];
   assign rise = ~ph_prev & ph_sync[1];

   // Next-state logic for the access sequencer
   always_comb begin
      next_state    = state;
      next_ph_prev  = ph_sync[1];
      next_req_n    = req_n;
      next_wr       = wr;
      next_addr     = addr;
      next_int_taken = 1'b0;
      next_done     = 1'b0;
      next_units    = units;
      next_fetch    = fetch;
      // Test-port reset must be seen low once after system reset
      // before the core may leave its reset state
      next_tst_ok   = tst_ok | ~tst_sync[1];
      // Core reset, or a test port never reset, keeps the core idle
      // with cache, translation and buffer off
      if (!rst_sync[1] || !tst_ok) begin
         next_state = CBC_RESET;
         next_units = 1'b0;
         next_req_n = 1'b1;
         next_fetch = `CBC_RESET_ADDR;
         if (rise)
            next_addr = addr + 32'h4;
      end else begin
         unique case (state)
            // First clock after reset: restart fetching from zero
            // and raise the unit enables
            CBC_RESET: begin
               next_state = CBC_IDLE;
               next_units = 1'b1;
               next_addr  = `CBC_RESET_ADDR;
               next_fetch = `CBC_RESET_ADDR;
               next_wr    = 1'b0;
               if (fall)
                  next_req_n = 1'b0;
            end
            // Request decided at a bus fall, address taken at the
            // following rise
            CBC_IDLE: begin
               if (fall)
                  next_req_n = ~i_want_access;
               if (rise) begin
                  next_wr = i_want_write;
                  if (!req_n) begin
                     next_addr  = i_access_addr;
                     next_state = CBC_ACCESS;
                  end
               end
            end
            CBC_ACCESS: begin
               // Wait low holds the cycle open; the done pulse and
               // the next request share the closing bus fall
               if (fall && stall_sync[1]) begin
                  next_done  = 1'b1;
                  next_fetch = addr;
                  next_req_n = ~i_want_access;
                  next_state = CBC_IDLE;
               end
            end
            default: next_state = CBC_RESET;
         endcase
         // Level interrupt, reported every clock it is low and enabled
         if (!irq_sync[1] && i_int_enable)
            next_int_taken = 1'b1;
      end
      // Cycle flag is registered from the same next value as the
      // request, so the two pins never disagree
      next_flag = ~next_req_n;
   end

   // Transparent output latches, held while latch enable is low.
   // They follow the next values, so the pins move on the same edge
   // as the state behind them.
   always_comb begin
      next_lat_addr = lat_addr;
      next_lat_wr   = lat_wr;
      if (bus.addr_latch_en) begin
         next_lat_addr = next_addr;
         next_lat_wr   = next_wr;
      end
   end

   // Register the sequencer state; every pin output comes from here
   // or from the latch registers below, never from a gate, so the
   // memory end sees clean edges.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state     <= CBC_RESET;
         ph_prev   <= 1'b0;
         req_n     <= 1'b1;
         wr        <= 1'b0;
         addr      <= `CBC_RESET_ADDR;
         flag      <= 1'b0;
         tst_ok    <= 1'b0;
         int_taken <= 1'b0;
         done      <= 1'b0;
         units     <= 1'b0;
         fetch     <= `CBC_RESET_ADDR;
      end else begin
         state     <= next_state;
         ph_prev   <= next_ph_prev;
         req_n     <= next_req_n;
         wr        <= next_wr;
         addr      <= next_addr;
         flag      <= next_flag;
         tst_ok    <= next_tst_ok;
         int_taken <= next_int_taken;
         done      <= next_done;
         units     <= next_units;
         fetch     <= next_fetch;
      end
   end

   // Output latch registers, kept apart from the sequencer so the latch
   // group has its own next-value logic and its own register process
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lat_addr <= `CBC_RESET_ADDR;
         lat_wr   <= 1'b0;
      end else begin
         lat_addr <= next_lat_addr;
         lat_wr   <= next_lat_wr;
      end
   end

   // Pin outputs, all from flip-flops; the test outputs have no test
   // logic behind them and stay low
   assign bus.ext_access_req_n     = req_n;
   assign bus.memory_cycle_flag    = flag;
   assign bus.write_not_read       = lat_wr;
   assign bus.addr                 = lat_addr;
   assign bus.factory_test_outputs = 3'h0;
   // Core-side status outputs
   assign o_int_taken     = int_taken;
   assign o_access_done   = done;
   assign o_units_enabled = units;
   assign o_fetch_addr    = fetch;
endmodule : cbc_device
`default_nettype wire

// >>> hdl/cbc_memctl.sv
// Memory controller end: makes the bus clock phase, reset, wait, straps.
// Assumes the processor end samples its control pins, except latch enable, through synchronisers.
`timescale 1ns/1ns
`default_nettype none
`include "cbc_params.svh"
module cbc_memctl
   import cbc_pkg::*;
#(
   parameter int WAIT_CYCLES = 1
)(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   cbc_if.mem               bus,
   input  wire logic        i_irq_n,
   input  wire logic        i_hold_latch,
   output logic             o_access_seen,
   output logic             o_access_write,
   output logic [31:0]      o_access_addr
);
   logic [7:0] div, next_div;
   logic       ph, next_ph;
   logic [7:0] rst_cnt, next_rst_cnt;
   logic       core_rst_n, next_core_rst_n;
   logic [7:0] wcnt, next_wcnt;
   logic       stall_n, next_stall_n;
   logic       seen, next_seen;
   logic       seen_wr, next_seen_wr;
   cbc_addr_t  seen_addr, next_seen_addr;
   logic       tick;

   assign tick = (div == `CBC_MCLK_DIV - 8'h1);

   // Bus clock divider, reset hold and wait insertion
   always_comb begin
      next_div        = tick ? 8'h0 : div + 8'h1;
      next_ph         = tick ? ~ph : ph;
      next_rst_cnt    = rst_cnt;
      next_core_rst_n = core_rst_n;
      next_wcnt       = wcnt;
      next_stall_n    = stall_n;
      next_seen       = 1'b0;
      next_seen_wr    = seen_wr;
      next_seen_addr  = seen_addr;
      if (tick && ph && !core_rst_n) begin
         // Five full bus periods exceed two fast periods
         if (rst_cnt == `CBC_RST_MCLK_MIN)
            next_core_rst_n = 1'b1;
         else
            next_rst_cnt = rst_cnt + 8'h1;
      end
      // Wait changes only as the low phase starts
      if (tick && ph) begin
         if (!core_rst_n) begin
            next_stall_n = 1'b1;
         end else if (!bus.ext_access_req_n && wcnt != WAIT_CYCLES[7:0]) begin
            next_stall_n = 1'b0;
            next_wcnt    = wcnt + 8'h1;
         end else begin
            next_stall_n = 1'b1;
            next_wcnt    = 8'h0;
            if (!bus.ext_access_req_n) begin
               next_seen      = 1'b1;
               next_seen_wr   = bus.write_not_read;
               next_seen_addr = bus.addr;
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div        <= 8'h0;
         ph         <= 1'b0;
         rst_cnt    <= 8'h0;
         core_rst_n <= 1'b0;
         wcnt       <= 8'h0;
         stall_n    <= 1'b1;
         seen       <= 1'b0;
         seen_wr    <= 1'b0;
         seen_addr  <= `CBC_RESET_ADDR;
      end else begin
         div        <= next_div;
         ph         <= next_ph;
         rst_cnt    <= next_rst_cnt;
         core_rst_n <= next_core_rst_n;
         wcnt       <= next_wcnt;
         stall_n    <= next_stall_n;
         seen       <= next_seen;
         seen_wr    <= next_seen_wr;
         seen_addr  <= next_seen_addr;
      end
   end

   // Pin drive toward the processor
   assign bus.mclk_high           = ph;
   assign bus.core_reset_n        = core_rst_n;
   assign bus.test_reset_n        = core_rst_n;
   assign bus.normal_int_req_n    = i_irq_n;
   assign bus.stall_request_n     = stall_n;
   assign bus.addr_latch_en       = ~i_hold_latch;
   assign bus.strap_high_input    = 1'b1;
   assign bus.factory_test_inputs = 17'h0;
   assign o_access_seen  = seen;
   assign o_access_write = seen_wr;
   assign o_access_addr  = seen_addr;
endmodule : cbc_memctl
`default_nettype wire

// >>> verif/cbc_checker.sv
// Checker: concurrent assertions on the bus control pins.
// Assumes it is instantiated beside the interface in the testbench.
`timescale 1ns/1ns
`default_nettype none
`include "cbc_params.svh"
module cbc_checker (
   input wire logic        i_clk,
   input wire logic        i_resetn,
   input wire logic        mclk_high,
   input wire logic        core_reset_n,
   input wire logic        stall_request_n,
   input wire logic        addr_latch_en,
   input wire logic        strap_high_input,
   input wire logic [16:0] factory_test_inputs,
   input wire logic [2:0]  factory_test_outputs,
   input wire logic        ext_access_req_n,
   input wire logic        memory_cycle_flag,
   input wire logic        write_not_read,
   input wire logic [31:0] addr
);
   // One edge of slack for the register alignment of the count
   localparam int RST_CLKS = 2 * `CBC_MCLK_DIV * `CBC_RST_MCLK_MIN - 1;
   logic [7:0] low_cnt;
   logic [7:0] next_low_cnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Counts clocks while core reset is held low, saturating
   always_comb begin
      next_low_cnt = core_reset_n ? 8'h00 : low_cnt + {7'h0, ~&low_cnt};
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) low_cnt <= 8'h00;
      else low_cnt <= next_low_cnt;
   end
   a_flag_inverse: assert property (memory_cycle_flag == !ext_access_req_n)
      else $error("cycle flag not inverse of request");
   a_req_low_phase: assert property ($changed(ext_access_req_n) |-> !mclk_high)
      else $error("request changed in high phase");
   a_dir_high_phase: assert property ($changed(write_not_read) |-> mclk_high)
      else $error("direction changed in low phase");
   a_latch_holds: assert property (!addr_latch_en && !$past(addr_latch_en)
      |-> $stable(addr) && $stable(write_not_read))
      else $error("latched outputs moved while held");
   a_test_out_low: assert property (factory_test_inputs == 17'h0
      |-> factory_test_outputs == 3'h0)
      else $error("test outputs not low");
   a_straps_tied: assert property (strap_high_input && factory_test_inputs == 17'h0)
      else $error("strap or test inputs not tied");
   a_reset_addr_step: assert property (!core_reset_n && !$past(core_reset_n)
      && $changed(addr) |-> addr == $past(addr) + 32'h4)
      else $error("reset idle address did not step by four");
   a_reset_wait_high: assert property (!core_reset_n |-> stall_request_n)
      else $error("wait low during reset");
   a_reset_length: assert property ($rose(core_reset_n) |-> low_cnt >= RST_CLKS)
      else $error("core reset too short");
   a_wait_low_phase: assert property ($changed(stall_request_n) |-> !mclk_high)
      else $error("wait changed in high phase");
endmodule : cbc_checker
`default_nettype wire

// >>> verif/tb.sv
// Testbench: both ends joined by the interface, self-checking.
// Assumes a 10 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        i_clk, i_resetn, int_en, want, want_wr, irq_n, hold;
   logic        int_taken, done, units, seen, seen_wr;
   logic [31:0] want_addr, fetch, seen_addr;
   int          n_mismatch = 0, comparisons = 0, cycles = 0;
   cbc_if bif ();
   cbc_device cbc_device_i (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bif.dev),
      .i_int_enable(int_en), .i_want_access(want), .i_want_write(want_wr),
      .i_access_addr(want_addr), .o_int_taken(int_taken),
      .o_access_done(done), .o_units_enabled(units), .o_fetch_addr(fetch));
   cbc_memctl #(.WAIT_CYCLES(2)) cbc_memctl_i (.i_clk(i_clk),
      .i_resetn(i_resetn), .bus(bif.mem), .i_irq_n(irq_n),
      .i_hold_latch(hold), .o_access_seen(seen),
      .o_access_write(seen_wr), .o_access_addr(seen_addr));
   cbc_checker cbc_checker_i (.i_clk(i_clk), .i_resetn(i_resetn),
      .mclk_high(bif.mclk_high), .core_reset_n(bif.core_reset_n),
      .stall_request_n(bif.stall_request_n), .addr_latch_en(bif.addr_latch_en),
      .strap_high_input(bif.strap_high_input),
      .factory_test_inputs(bif.factory_test_inputs),
      .factory_test_outputs(bif.factory_test_outputs),
      .ext_access_req_n(bif.ext_access_req_n),
      .memory_cycle_flag(bif.memory_cycle_flag),
      .write_not_read(bif.write_not_read), .addr(bif.addr));
   // Clock generator, 100 ns period
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic check(string name, logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic test_done();
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // Cuts a hang short
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         test_done();
      end
   end
   // Waits for the controller to report an access, then checks that it was seen
   task automatic wait_seen();
      int k;
      for (k = 0; k < 300 && seen !== 1'b1; k++) @(negedge i_clk);
      check("access seen", {31'h0, seen}, 32'h1);
   endtask : wait_seen
   task automatic go_idle();
      int k;
      want = 1'b0;
      for (k = 0; k < 300 && bif.ext_access_req_n !== 1'b1; k++)
         @(negedge i_clk);
      check("access done", {31'h0, done}, 32'h1);
      repeat (16) @(negedge i_clk);
   endtask : go_idle
   // Reset held six cycles; core reset must then stay low long enough
   task automatic t_reset();
      int k;
      i_resetn = 1'b0;
      repeat (6) @(negedge i_clk);
      check("units in reset", {31'h0, units}, 32'h0);
      check("request idle", {31'h0, bif.ext_access_req_n}, 32'h1);
      i_resetn = 1'b1;
      @(negedge i_clk);
      check("test reset", {31'h0, bif.test_reset_n}, 32'h0);
      for (k = 0; k < 300 && bif.core_reset_n !== 1'b1; k++) begin
         check("units held off", {31'h0, units}, 32'h0);
         @(negedge i_clk);
      end
      check("reset long", {31'h0, k >= 38}, 32'h1);
      check("fetch start", fetch, 32'h0);
      repeat (4) @(negedge i_clk);
      check("units enabled", {31'h0, units}, 32'h1);
   endtask : t_reset
   // One access, judged at the controller end and by the processor's done pulse and fetch address
   task automatic t_access(logic wr, logic [31:0] a);
      want = 1'b1;
      want_wr = wr;
      want_addr = a;
      wait_seen();
      check("access address", seen_addr, a);
      check("access direction", {31'h0, seen_wr}, {31'h0, wr});
      go_idle();
      check("fetch address", fetch, a);
   endtask : t_access
   // Interrupt ignored while disabled, taken once enabled
   task automatic t_irq();
      int k, hit;
      hit = 0;
      irq_n = 1'b0;
      for (k = 0; k < 24; k++) begin
         @(negedge i_clk);
         if (int_taken !== 1'b0) hit++;
      end
      check("masked interrupt", hit, 0);
      int_en = 1'b1;
      for (k = 0; k < 24 && int_taken !== 1'b1; k++) @(negedge i_clk);
      check("interrupt taken", {31'h0, int_taken}, 32'h1);
      irq_n = 1'b1;
      int_en = 1'b0;
   endtask : t_irq
   // Address held while the latch is closed, even with a request
   task automatic t_hold();
      logic [31:0] a;
      hold = 1'b1;
      repeat (4) @(negedge i_clk);
      a = bif.addr;
      want = 1'b1;
      want_wr = 1'b1;
      want_addr = 32'h0000_3000;
      repeat (24) @(negedge i_clk);
      check("held address", bif.addr, a);
      // Reopen the latch just after a bus rise so the pins move high
      while (bif.mclk_high !== 1'b0) @(negedge i_clk);
      while (bif.mclk_high !== 1'b1) @(negedge i_clk);
      hold = 1'b0;
      wait_seen();
      check("released address", seen_addr, 32'h0000_3000);
      check("released direction", {31'h0, seen_wr}, 32'h1);
      go_idle();
   endtask : t_hold
   // Main sequence, second reset in mid-run
   initial begin
      {i_resetn, int_en, want, want_wr, hold} = 5'h00;
      irq_n = 1'b1;
      want_addr = 32'h0;
      @(negedge i_clk);
      t_reset();
      t_access(1'b1, 32'h0000_1000);
      t_access(1'b0, 32'hffff_fffc);
      t_irq();
      t_hold();
      t_reset();
      t_access(1'b0, 32'h0000_0004);
      test_done();
   end
endmodule : tb
`default_nettype wire
